// File: src/table_access_pkg.sv
// Purpose: shared constants and types for the program memory table access block
// Assumes: one instruction cycle per enable pulse from the core
// Notes: pointer and latch widths follow the byte-addressed program space
package table_access_pkg;
  localparam int PTR_WIDTH = 21;
  localparam int DATA_WIDTH = 8;
  localparam int HOLD_COUNT = 8;
  localparam int HOLD_SEL_WIDTH = 3;
  localparam logic [PTR_WIDTH-1:0] PTR_RESET = 21'h000000;
  localparam logic [DATA_WIDTH-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] HOLD_RESET = 8'hFF;
  localparam logic [PTR_WIDTH-1:0] PTR_ONE = 21'h000001;
  localparam logic [1:0] OP_READ_CODE = 2'h2;
  localparam logic [1:0] OP_WRITE_CODE = 2'h3;

  typedef enum logic [1:0] {
    UPD_NONE = 2'b00,
    UPD_POST_INC = 2'b01,
    UPD_POST_DEC = 2'b10,
    UPD_PRE_INC = 2'b11
  } pointer_update_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } table_state_t;

  typedef struct packed {
    logic valid;
    logic [1:0] opClass;
    pointer_update_mode_t mode;
  } table_cmd_t;

  typedef struct packed {
    logic valid;
    logic [PTR_WIDTH-1:0] addr;
  } fetch_req_t;
endpackage

// File: src/program_memory_table_access.sv
// Purpose: executes table read and table write operations for an 8-bit core
// Assumes: cmd.valid is a one-cycle pulse; memData answers in the same cycle as fetch.valid
// Notes: flash commit of the holding registers is outside this block
`timescale 1ns/100ps

// Function
// R1 - A table read loads the program byte at the pointer into the latch.
// R2 - The pointer is 21 bits and addresses single bytes over 2 Mbyte.
// R3 - Pointer bit 0 picks low byte (0) or high byte (1) of a word.
// R4 - Mode 0 keeps, 1 post-increments, 2 post-decrements, 3 pre-increments the pointer.
// R5 - Each operation takes two cycles, transfers in the second, alters no flags.
// R6 - A table write copies the latch into the holding register chosen by pointer[2:0].
// R7 - Eight holding registers stage data for later programming, not direct writes.
// R8 - Pointer increments and decrements wrap modulo two to the twenty-first.
module program_memory_table_access
  import table_access_pkg::*;
#(
  parameter int PtrWidth = PTR_WIDTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cycleEn,
  input wire table_cmd_t cmd,
  input wire logic ptrLoad,
  input wire logic [PTR_WIDTH-1:0] ptrLoadValue,
  input wire logic latchLoad,
  input wire logic [DATA_WIDTH-1:0] latchLoadValue,
  input wire logic [DATA_WIDTH-1:0] memData,
  output fetch_req_t fetch,
  output logic [PTR_WIDTH-1:0] tablePointer,
  output logic [DATA_WIDTH-1:0] tableLatch,
  output logic [HOLD_COUNT*DATA_WIDTH-1:0] holdingData,
  output logic busy,
  output logic highByteSel,
  output logic opDone
);

  // ----------------------------------------
  // Pointer arithmetic
  // ----------------------------------------
  function automatic logic [PTR_WIDTH-1:0] stepPtr(input logic [PTR_WIDTH-1:0] p,
                                                    input logic down);
    if (down) begin
      stepPtr = p - PTR_ONE; // [R8]
    end else begin
      stepPtr = p + PTR_ONE; // [R8]
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  table_state_t state_reg, state_next;
  pointer_update_mode_t mode_reg, mode_next;
  logic [PTR_WIDTH-1:0] ptr_reg, ptr_next;
  logic [PTR_WIDTH-1:0] addr_reg, addr_next;
  logic [DATA_WIDTH-1:0] latch_reg, latch_next;
  logic [DATA_WIDTH-1:0] hold_reg [HOLD_COUNT];
  logic [DATA_WIDTH-1:0] hold_next [HOLD_COUNT];
  fetch_req_t fetch_next;
  logic done_next;
  logic [PTR_WIDTH-1:0] accessAddr;

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    ptr_next = ptr_reg;
    addr_next = addr_reg;
    latch_next = latch_reg;
    fetch_next = '0;
    done_next = 1'b0;
    for (int i = 0; i < HOLD_COUNT; i++) begin
      hold_next[i] = hold_reg[i];
    end
    // Pre-increment computes the access address from the stepped pointer
    accessAddr = (cmd.mode == UPD_PRE_INC) ? stepPtr(ptr_reg, 1'b0) : ptr_reg; // [R4]
    if (ptrLoad) begin
      ptr_next = ptrLoadValue; // [R2]
    end
    if (latchLoad) begin
      latch_next = latchLoadValue;
    end
    if (cycleEn) begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd.valid && (cmd.opClass == OP_READ_CODE || cmd.opClass == OP_WRITE_CODE)) begin
            mode_next = cmd.mode;
            addr_next = accessAddr;
            state_next = (cmd.opClass == OP_READ_CODE) ? ST_READ : ST_WRITE; // [R5]
            if (cmd.opClass == OP_READ_CODE) begin
              fetch_next.valid = 1'b1;
              fetch_next.addr = accessAddr; // [R1] [R3]
            end
          end
        end
        ST_READ: begin
          latch_next = memData; // [R1] [R5]
          state_next = ST_IDLE;
          done_next = 1'b1;
        end
        ST_WRITE: begin
          // Staged only; the array is programmed later from these bytes
          hold_next[addr_reg[HOLD_SEL_WIDTH-1:0]] = latch_reg; // [R6] [R7]
          state_next = ST_IDLE;
          done_next = 1'b1;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
      if (state_reg == ST_READ || state_reg == ST_WRITE) begin
        case (mode_reg)
          UPD_NONE: ptr_next = ptr_reg;
          UPD_POST_INC: ptr_next = stepPtr(addr_reg, 1'b0); // [R4]
          UPD_POST_DEC: ptr_next = stepPtr(addr_reg, 1'b1); // [R4]
          UPD_PRE_INC: ptr_next = addr_reg; // [R4]
          default: ptr_next = ptr_reg;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      mode_reg <= UPD_NONE;
      ptr_reg <= PTR_RESET;
      addr_reg <= PTR_RESET;
      latch_reg <= LATCH_RESET;
      fetch <= '0;
      opDone <= 1'b0;
      for (int i = 0; i < HOLD_COUNT; i++) begin
        hold_reg[i] <= HOLD_RESET;
      end
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      ptr_reg <= ptr_next;
      addr_reg <= addr_next;
      latch_reg <= latch_next;
      fetch <= fetch_next;
      opDone <= done_next;
      for (int i = 0; i < HOLD_COUNT; i++) begin
        hold_reg[i] <= hold_next[i];
      end
    end
  end

  // ----------------------------------------
  // Outputs, all registered
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tablePointer <= PTR_RESET;
      tableLatch <= LATCH_RESET;
      busy <= 1'b0;
      highByteSel <= 1'b0;
    end else begin
      tablePointer <= ptr_next;
      tableLatch <= latch_next;
      busy <= (state_next != ST_IDLE);
      highByteSel <= ptr_next[0]; // [R3]
    end
  end

  genvar g;
  generate
    for (g = 0; g < HOLD_COUNT; g++) begin : gHold
      assign holdingData[g*DATA_WIDTH +: DATA_WIDTH] = hold_reg[g];
    end
  endgenerate

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_readLatch;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg == ST_READ) |=> (tableLatch == $past(memData));
  endproperty
  a_readLatch: assert property (p_readLatch) else $error("latch missed read data"); // [R1]

  property p_twoCycles;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg == ST_IDLE && cmd.valid && cmd.opClass[1]) |=> (state_reg != ST_IDLE);
  endproperty
  a_twoCycles: assert property (p_twoCycles) else $error("operation did not start"); // [R5]

  property p_postInc;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg != ST_IDLE && mode_reg == UPD_POST_INC && !ptrLoad)
      |=> (tablePointer == $past(addr_reg) + PTR_ONE);
  endproperty
  a_postInc: assert property (p_postInc) else $error("post increment wrong"); // [R4] [R8]

  property p_postDec;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg != ST_IDLE && mode_reg == UPD_POST_DEC && !ptrLoad)
      |=> (tablePointer == $past(addr_reg) - PTR_ONE);
  endproperty
  a_postDec: assert property (p_postDec) else $error("post decrement wrong"); // [R4] [R8]

  property p_holdWrite;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg == ST_WRITE)
      |=> (hold_reg[$past(addr_reg[HOLD_SEL_WIDTH-1:0])] == $past(latch_reg));
  endproperty
  a_holdWrite: assert property (p_holdWrite) else $error("holding write wrong"); // [R6] [R7]

  property p_byteSel;
    @(posedge core_clk) disable iff (sys_rst)
    1'b1 |-> (highByteSel == tablePointer[0]);
  endproperty
  a_byteSel: assert property (p_byteSel) else $error("byte select mismatch"); // [R3]

  // Checked against the pointer as it stood when the read was taken, so a wrong pre-increment shows
  property p_fetchAddr;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg == ST_IDLE && cmd.valid && cmd.opClass == OP_READ_CODE)
      |=> (fetch.valid && fetch.addr == (($past(cmd.mode) == UPD_PRE_INC) ?
                                         $past(ptr_reg) + PTR_ONE : $past(ptr_reg)));
  endproperty
  a_fetchAddr: assert property (p_fetchAddr) else $error("fetch address wrong"); // [R1] [R2] [R4]

  property p_doneAfter;
    @(posedge core_clk) disable iff (sys_rst)
    (cycleEn && state_reg != ST_IDLE) |=> opDone;
  endproperty
  a_doneAfter: assert property (p_doneAfter) else $error("done missing"); // [R5]

endmodule

// File: dv/prog_mem_model.sv
// Purpose: program flash model that answers table fetches
// Assumes: the byte is needed while fetch.valid is high
// Notes: a released bus shows the inverse of the last byte, never a stale copy
`timescale 1ns/100ps
module prog_mem_model
  import table_access_pkg::*;
(
  input wire logic core_clk,
  input wire fetch_req_t fetch,
  output logic [DATA_WIDTH-1:0] memData
);
  logic [DATA_WIDTH-1:0] lastData = 8'h00;
  always @(posedge core_clk) begin
    if (fetch.valid) begin
      lastData <= memData;
    end
  end
  // Pattern mixes low and high address bits so a wrong address shows
  assign memData = fetch.valid ? (fetch.addr[7:0] ^ fetch.addr[20:13] ^ 8'hA5) : ~lastData;
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the table access block
// Assumes: cycleEn held high, so each operation spans two clocks
// Notes: rows cover both table opClass codes (read, write) in every update mode
`timescale 1ns/100ps
module testbench;
  import table_access_pkg::*;
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] md;
    logic [20:0] ptr;
    logic [20:0] addr;
    logic [20:0] nxt;
    logic [7:0] lat;
  } row_t;
  row_t rows [8] = '{'{2'h2, 2'h0, 21'h00A356, 21'h00A356, 21'h00A356, 8'h00},
    '{2'h2, 2'h1, 21'h00A356, 21'h00A356, 21'h00A357, 8'h00},
    '{2'h2, 2'h2, 21'h000000, 21'h000000, 21'h1FFFFF, 8'h00},
    '{2'h2, 2'h3, 21'h01A357, 21'h01A358, 21'h01A358, 8'h00},
    '{2'h3, 2'h0, 21'h000005, 21'h000005, 21'h000005, 8'h11},
    '{2'h3, 2'h1, 21'h1FFFFF, 21'h1FFFFF, 21'h000000, 8'h22},
    '{2'h3, 2'h2, 21'h00A357, 21'h00A357, 21'h00A356, 8'h55},
    '{2'h3, 2'h3, 21'h01389A, 21'h01389B, 21'h01389B, 8'h34}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cycleEn = 1'b1;
  table_cmd_t cmd = '0;
  logic ptrLoad = 1'b0;
  logic [PTR_WIDTH-1:0] ptrLoadValue = '0;
  logic latchLoad = 1'b0;
  logic [DATA_WIDTH-1:0] latchLoadValue = '0;
  logic [DATA_WIDTH-1:0] memData;
  fetch_req_t fetch;
  logic [PTR_WIDTH-1:0] tablePointer;
  logic [PTR_WIDTH-1:0] seenAddr;
  logic [DATA_WIDTH-1:0] tableLatch;
  logic [HOLD_COUNT*DATA_WIDTH-1:0] holdingData;
  logic [HOLD_COUNT*DATA_WIDTH-1:0] expHold = {HOLD_COUNT{8'hFF}};
  logic busy;
  logic highByteSel;
  logic opDone;
  int n_errors = 0;
  int num_checks = 0;
  int cyc;
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (fetch.valid) begin
      seenAddr <= fetch.addr;
    end
  end
  program_memory_table_access dut (.core_clk(core_clk), .sys_rst(sys_rst), .cycleEn(cycleEn), .cmd(cmd),
    .ptrLoad(ptrLoad), .ptrLoadValue(ptrLoadValue), .latchLoad(latchLoad), .latchLoadValue(latchLoadValue),
    .memData(memData), .fetch(fetch), .tablePointer(tablePointer), .tableLatch(tableLatch),
    .holdingData(holdingData), .busy(busy), .highByteSel(highByteSel), .opDone(opDone));
  prog_mem_model mem (.core_clk(core_clk), .fetch(fetch), .memData(memData));
  // ----------------
  // Tasks
  // ----------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Loads pointer and latch, then gives one command and waits for completion
  task automatic run_op(input row_t r);
    @(negedge core_clk);
    ptrLoad <= 1'b1;
    ptrLoadValue <= r.ptr;
    latchLoad <= 1'b1;
    latchLoadValue <= r.lat;
    @(negedge core_clk);
    ptrLoad <= 1'b0;
    latchLoad <= 1'b0;
    cmd <= '{1'b1, r.op, pointer_update_mode_t'(r.md)};
    @(negedge core_clk);
    cmd <= '0;
    check(busy, 1'b1);
    cyc = 1;
    while (opDone !== 1'b1 && cyc < 10) begin
      @(negedge core_clk);
      cyc++;
    end
    if (cyc >= 10) begin
      n_errors++;
      end_of_test();
    end
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    check(tablePointer, PTR_RESET);
    check(holdingData, expHold);
    foreach (rows[i]) begin
      run_op(rows[i]);
      check(cyc, 2);
      check(tablePointer, rows[i].nxt);
      check(highByteSel, rows[i].nxt[0]);
      if (rows[i].op == OP_READ_CODE) begin
        check(seenAddr, rows[i].addr);
        check(tableLatch, rows[i].addr[7:0] ^ rows[i].addr[20:13] ^ 8'hA5);
      end else begin
        expHold[rows[i].addr[2:0]*8 +: 8] = rows[i].lat;
        check(holdingData, expHold);
      end
    end
    // A command held into the busy cycle must be dropped: one increment only
    @(negedge core_clk);
    ptrLoad <= 1'b1;
    ptrLoadValue <= 21'h000010;
    @(negedge core_clk);
    ptrLoad <= 1'b0;
    cmd <= '{1'b1, OP_READ_CODE, UPD_POST_INC};
    @(negedge core_clk);
    check(busy, 1'b1);
    @(negedge core_clk);
    cmd <= '0;
    check(opDone, 1'b1);
    check(tableLatch, 8'hB5);
    @(negedge core_clk);
    check(busy, 1'b0);
    check(opDone, 1'b0);
    check(tablePointer, 21'h000011);
    // Unknown operation class starts nothing and leaves the pointer alone
    @(negedge core_clk);
    ptrLoad <= 1'b1;
    ptrLoadValue <= 21'h000020;
    @(negedge core_clk);
    ptrLoad <= 1'b0;
    cmd <= '{1'b1, 2'h1, UPD_POST_INC};
    @(negedge core_clk);
    cmd <= '0;
    check(busy, 1'b0);
    check(fetch.valid, 1'b0);
    @(negedge core_clk);
    check(opDone, 1'b0);
    check(tablePointer, 21'h000020);
    // Reset in mid-run restores pointer, latch and holding bytes, then work resumes
    sys_rst <= 1'b1;
    @(negedge core_clk);
    expHold = {HOLD_COUNT{HOLD_RESET}};
    check(tablePointer, PTR_RESET);
    check(tableLatch, LATCH_RESET);
    check(holdingData, expHold);
    sys_rst <= 1'b0;
    run_op(rows[7]);
    check(cyc, 2);
    expHold[rows[7].addr[2:0]*8 +: 8] = rows[7].lat;
    check(holdingData, expHold);
    check(tablePointer, rows[7].nxt);
    end_of_test();
  end
endmodule
